// file: rtl/rcf_pkg.sv
// Constants, carriers and state layouts for the control and flag logic
// of a serial real-time clock. Assumes a 10 MHz system clock.
//
// Overview of operation
// - Writing one to the adjust bit starts adjustment; busy lasts at most 122.1 us.
// - Adjustment requested with carry disabled waits until carry is enabled again.
// - Adjust at seconds 00-29 clears sub-second stages and seconds, minutes untouched.
// - Adjust at seconds 30-59 clears sub-second stages and seconds, minutes plus one.
// - Busy reads one during counter updates; host writes counters only when idle.
// - Carry enable at zero holds back the one-second carry into the counter.
// - Chip enable low forces carry enable to one; host restores it too.
// - A carry held back is remembered and applied once carry is re-enabled.
// - With chip enable low a stopped oscillator sets the sticky halt flag.
// - With chip enable high the halt flag is not sampled; only a control-one write can clear it.
// - Any write to control one with running oscillator clears the halt flag.
// - Enabled alarm match sets the alarm flag and pulls the interrupt low.
// - Periodic flag reads one while a periodic event holds the interrupt low.
// - Top cycle-code bit selects pulse mode at zero, level mode at one.
// - In level mode host writes the periodic flag: one pulls low, zero releases.
// - Pulse mode codes x00 keep the interrupt off, x01 hold it low.
// - Pulse mode x10 gives 0.977 ms square wave, x11 gives 0.5 s period.
// - Level codes 1000-1011: every second, ten seconds, minute, ten minutes.
// - Level codes 1100-1111: every hour, day, week at weekday zero, month.
// - Alarm enable at zero blocks matching; only enabled alarms set the flag.
package rcf_pkg;

	localparam logic [3:0] ADDR_CTRL_ONE  = 4'hE;
	localparam logic [3:0] ADDR_IRQ_CYCLE = 4'h7;

	localparam int BIT_PERIODIC_FLAG = 3;
	localparam int BIT_ALARM_FLAG    = 2;
	localparam int BIT_CARRY_EN      = 1;
	localparam int BIT_ADJUST        = 0;
	localparam int BIT_LEVEL_MODE    = 3;
	localparam int SLOW_WAVE_BIT     = 9;

	localparam int CLK_PERIOD_NS = 100;
	localparam int BUSY_MAX_NS   = 122_100;
	localparam int BUSY_CYC      = BUSY_MAX_NS / CLK_PERIOD_NS;
	localparam int SQW_PERIOD_NS = 977_000;
	localparam int SQW_HALF_CYC  = SQW_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam logic [10:0] BUSY_LAST = 11'(BUSY_CYC - 1);

	localparam logic [5:0] SEC_MAX  = 6'h3B;
	localparam logic [5:0] SEC_HALF = 6'h1E;
	localparam logic [5:0] MIN_MAX  = 6'h3B;
	localparam logic [5:0] DIGIT_TEN = 6'h0A;
	localparam logic [4:0] HOUR_MAX = 5'h17;
	localparam logic [2:0] WDAY_MAX = 3'h6;
	localparam logic [4:0] DAY_FIRST = 5'h01;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} rcf_seq_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [3:0] data;
	} rcf_access_t;

	typedef struct packed {
		logic [5:0] sec;
		logic [5:0] min;
		logic [4:0] hour;
		logic [2:0] wday;
		logic [4:0] day;
	} rcf_time_t;

	typedef struct packed {
		rcf_seq_t    seq;
		logic [10:0] busy_cnt;
		logic [12:0] half_cnt;
		logic [10:0] sub;
		rcf_time_t   tm;
		logic        carry_en;
		logic        adj_pend;
		logic        carry_pend;
		logic        osc_halt;
		logic        alarm_flag;
		logic        periodic_flag;
		logic        irq_n;
		logic        step_evt;
		logic [3:0]  cycle;
		logic [2:0]  ce_sy;
		logic        ce_f;
		logic [2:0]  osc_sy;
		logic        osc_f;
		logic [2:0]  req_sy;
		logic        ack_tgl;
		logic [2:0]  pub_ack_sy;
		logic        pub_ack_f;
		logic        pub_tgl;
		logic [7:0]  pub_data;
	} rcf_sys_t;

	typedef struct packed {
		logic        req_tgl;
		rcf_access_t hold;
		logic [2:0]  ack_sy;
		logic        ack_f;
		logic [2:0]  pub_sy;
		logic        pub_seen;
		logic [3:0]  ctrl_rd;
		logic [3:0]  cycle_rd;
		logic [3:0]  rdata;
	} rcf_link_t;

	localparam rcf_sys_t SYS_RESET = '{
		seq:      ST_IDLE,
		tm:       '{day: DAY_FIRST, default: '0},
		carry_en: 1'b1,
		irq_n:    1'b1,
		ce_sy:    3'b111,
		ce_f:     1'b1,
		osc_sy:   3'b111,
		osc_f:    1'b1,
		default:  '0
	};
	localparam rcf_link_t LINK_RESET = '0;

endpackage : rcf_pkg

// file: rtl/rcf_top.sv
// Control register one, interrupt cycle register, busy sequencer,
// oscillator-halt, alarm and periodic interrupt logic of the clock.
// Assumes the serial framer hands over decoded nibble accesses on the
// link clock; alarm compare and month length come from same-clock logic.
`timescale 1ns/1ps
`default_nettype none
module rcf_top #(
	parameter int unsigned HALF_CYC = rcf_pkg::SQW_HALF_CYC
) (
	input  wire logic                SYS_CLK_IN,
	input  wire logic                RST_N_IN,
	input  wire logic                CE_IN,
	input  wire logic                OSC_RUN_IN,
	input  wire logic                ALARM_ENABLE_IN,
	input  wire logic                ALARM_MATCH_IN,
	input  wire logic [4:0]          MONTH_DAYS_IN,
	input  wire logic                LINK_CLK_IN,
	input  wire logic                LINK_WR_IN,
	input  wire rcf_pkg::rcf_access_t LINK_ACC_IN,
	input  wire logic [3:0]          LINK_RADDR_IN,
	output logic                     LINK_WR_READY_OUT,
	output logic [3:0]               LINK_RDATA_OUT,
	output logic                     IRQ_N_OUT,
	output rcf_pkg::rcf_time_t       TIME_OUT
);
	import rcf_pkg::*;

	localparam logic [12:0] HALF_LAST = 13'(HALF_CYC - 1);
	localparam int BUSY_LIM = BUSY_CYC;

	rcf_sys_t  sq, sn;
	rcf_link_t lq, ln;

	logic       wr_take;
	logic       ctrl_wr;
	logic       cyc_wr;
	logic [3:0] wd;
	logic       half_tick;
	logic       sec_carry;
	logic       adj_go;
	logic       sec_go;
	logic       min_go;
	logic       hour_go;
	logic       day_go;
	logic       busy;
	logic       evt_hit;
	logic       evt;
	logic       pulse_low;
	logic       wr_ready;

	assign busy = sq.seq == ST_BUSY;

	always_comb begin
		sn = sq;
		wr_take = 1'b0;
		min_go = 1'b0;
		hour_go = 1'b0;
		day_go = 1'b0;
		evt_hit = 1'b0;
		pulse_low = 1'b0;
		// Pins and toggles from the link pass three stages
		sn.ce_sy = {sq.ce_sy[1:0], CE_IN};
		if (sq.ce_sy[1] == sq.ce_sy[2]) begin
			sn.ce_f = sq.ce_sy[2];
		end
		sn.osc_sy = {sq.osc_sy[1:0], OSC_RUN_IN};
		if (sq.osc_sy[1] == sq.osc_sy[2]) begin
			sn.osc_f = sq.osc_sy[2];
		end
		sn.req_sy = {sq.req_sy[1:0], lq.req_tgl};
		sn.pub_ack_sy = {sq.pub_ack_sy[1:0], lq.pub_seen};
		if (sq.pub_ack_sy[1] == sq.pub_ack_sy[2]) begin
			sn.pub_ack_f = sq.pub_ack_sy[2];
		end
		// Held access is stable until this side toggles its ack back
		if (sq.req_sy[1] == sq.req_sy[2] && sq.req_sy[2] != sq.ack_tgl) begin
			wr_take = 1'b1;
			sn.ack_tgl = sq.req_sy[2];
		end
		wd = lq.hold.data;
		ctrl_wr = wr_take && lq.hold.addr == ADDR_CTRL_ONE;
		cyc_wr = wr_take && lq.hold.addr == ADDR_IRQ_CYCLE;
		if (cyc_wr) begin
			sn.cycle = wd;
		end

		// Timebase: half periods of the 1024 Hz wave, 2048 per second
		half_tick = sq.half_cnt == HALF_LAST;
		sn.half_cnt = half_tick ? 13'h0000 : sq.half_cnt + 13'h0001;
		if (half_tick) begin
			sn.sub = sq.sub + 11'h001;
		end
		sec_carry = half_tick && (&sq.sub);

		if (ctrl_wr) begin
			sn.carry_en = wd[BIT_CARRY_EN];
		end
		if (!sq.ce_f) begin
			sn.carry_en = 1'b1;
		end
		// Adjust waits for carry enable; the written enable counts at once
		adj_go = ((ctrl_wr && wd[BIT_ADJUST]) || sq.adj_pend) && sn.carry_en;
		if (ctrl_wr && wd[BIT_ADJUST] && !sn.carry_en) begin
			sn.adj_pend = 1'b1;
		end
		if (adj_go) begin
			sn.adj_pend = 1'b0;
		end
		sec_go = !adj_go && sn.carry_en && (sec_carry || sq.carry_pend);
		if (sec_carry && !sn.carry_en) begin
			sn.carry_pend = 1'b1;
		end
		// Adjust resets the sub-second chain, so a held carry is void
		if (sec_go || adj_go) begin
			sn.carry_pend = 1'b0;
		end

		if (adj_go) begin
			sn.sub = 11'h000;
			sn.half_cnt = 13'h0000;
			sn.tm.sec = 6'h00;
			min_go = sq.tm.sec >= SEC_HALF;
		end else if (sec_go) begin
			if (sq.tm.sec == SEC_MAX) begin
				sn.tm.sec = 6'h00;
				min_go = 1'b1;
			end else begin
				sn.tm.sec = sq.tm.sec + 6'h01;
			end
		end
		if (min_go) begin
			if (sq.tm.min == MIN_MAX) begin
				sn.tm.min = 6'h00;
				hour_go = 1'b1;
			end else begin
				sn.tm.min = sq.tm.min + 6'h01;
			end
		end
		if (hour_go) begin
			if (sq.tm.hour == HOUR_MAX) begin
				sn.tm.hour = 5'h00;
				day_go = 1'b1;
			end else begin
				sn.tm.hour = sq.tm.hour + 5'h01;
			end
		end
		if (day_go) begin
			sn.tm.wday = (sq.tm.wday == WDAY_MAX) ? 3'h0 : sq.tm.wday + 3'h1;
			sn.tm.day = (sq.tm.day >= MONTH_DAYS_IN) ? DAY_FIRST
				: sq.tm.day + 5'h01;
		end
		sn.step_evt = sec_go;

		// A new update restarts the window; each update is covered alone
		case (sq.seq)
			ST_IDLE: begin
				if (adj_go || sec_go) begin
					sn.seq = ST_BUSY;
					sn.busy_cnt = BUSY_LAST;
				end
			end
			ST_BUSY: begin
				if (adj_go || sec_go) begin
					sn.busy_cnt = BUSY_LAST;
				end else if (sq.busy_cnt == 11'h000) begin
					sn.seq = ST_IDLE;
				end else begin
					sn.busy_cnt = sq.busy_cnt - 11'h001;
				end
			end
			default: begin
				sn.seq = ST_IDLE;
				sn.busy_cnt = 11'h000;
			end
		endcase

		// Set wins over the clearing write
		if (ctrl_wr && sq.osc_f) begin
			sn.osc_halt = 1'b0;
		end
		if (!sq.ce_f && !sq.osc_f) begin
			sn.osc_halt = 1'b1;
		end
		if (ctrl_wr && !wd[BIT_ALARM_FLAG]) begin
			sn.alarm_flag = 1'b0;
		end
		if (ALARM_ENABLE_IN && ALARM_MATCH_IN) begin
			sn.alarm_flag = 1'b1;
		end

		// Events judged on the counters one cycle after the step
		case (sq.cycle[2:0])
			3'h0: evt_hit = 1'b1;
			3'h1: evt_hit = (sq.tm.sec % DIGIT_TEN) == 6'h00;
			3'h2: evt_hit = sq.tm.sec == 6'h00;
			3'h3: evt_hit = sq.tm.sec == 6'h00
				&& (sq.tm.min % DIGIT_TEN) == 6'h00;
			3'h4: evt_hit = sq.tm.sec == 6'h00 && sq.tm.min == 6'h00;
			3'h5: evt_hit = sq.tm.sec == 6'h00 && sq.tm.min == 6'h00
				&& sq.tm.hour == 5'h00;
			3'h6: evt_hit = sq.tm.sec == 6'h00 && sq.tm.min == 6'h00
				&& sq.tm.hour == 5'h00 && sq.tm.wday == 3'h0;
			3'h7: evt_hit = sq.tm.sec == 6'h00 && sq.tm.min == 6'h00
				&& sq.tm.hour == 5'h00 && sq.tm.day == DAY_FIRST;
			default: evt_hit = 1'b0;
		endcase
		evt = sq.step_evt && sq.cycle[BIT_LEVEL_MODE] && evt_hit;

		case (sn.cycle[1:0])
			2'h0: pulse_low = 1'b0;
			2'h1: pulse_low = 1'b1;
			2'h2: pulse_low = sn.sub[0];
			2'h3: pulse_low = sn.sub[SLOW_WAVE_BIT];
			default: pulse_low = 1'b0;
		endcase
		if (sn.cycle[BIT_LEVEL_MODE]) begin
			if (ctrl_wr) begin
				sn.periodic_flag = wd[BIT_PERIODIC_FLAG];
			end
			if (evt) begin
				sn.periodic_flag = 1'b1;
			end
		end else begin
			sn.periodic_flag = pulse_low;
		end
		sn.irq_n = !(sn.periodic_flag || sn.alarm_flag);

		// Snapshot for the link; frozen until the link has taken it
		if (sq.pub_ack_f == sq.pub_tgl) begin
			sn.pub_data = {sq.periodic_flag, sq.alarm_flag, sq.osc_halt,
				busy, sq.cycle};
			sn.pub_tgl = ~sq.pub_tgl;
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			sq <= SYS_RESET;
		end else begin
			sq <= sn;
		end
	end

	always_comb begin
		ln = lq;
		ln.ack_sy = {lq.ack_sy[1:0], sq.ack_tgl};
		if (lq.ack_sy[1] == lq.ack_sy[2]) begin
			ln.ack_f = lq.ack_sy[2];
		end
		wr_ready = lq.req_tgl == lq.ack_f;
		// Only one access in flight; others wait on the ready handshake
		if (LINK_WR_IN && wr_ready && (LINK_ACC_IN.addr == ADDR_CTRL_ONE
			|| LINK_ACC_IN.addr == ADDR_IRQ_CYCLE)) begin
			ln.hold = LINK_ACC_IN;
			ln.req_tgl = ~lq.req_tgl;
		end
		ln.pub_sy = {lq.pub_sy[1:0], sq.pub_tgl};
		if (lq.pub_sy[1] == lq.pub_sy[2] && lq.pub_sy[2] != lq.pub_seen) begin
			ln.ctrl_rd = sq.pub_data[7:4];
			ln.cycle_rd = sq.pub_data[3:0];
			ln.pub_seen = lq.pub_sy[2];
		end
		case (LINK_RADDR_IN)
			ADDR_CTRL_ONE:  ln.rdata = lq.ctrl_rd;
			ADDR_IRQ_CYCLE: ln.rdata = lq.cycle_rd;
			default:        ln.rdata = 4'h0;
		endcase
	end

	always_ff @(posedge LINK_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			lq <= LINK_RESET;
		end else begin
			lq <= ln;
		end
	end

	assign LINK_WR_READY_OUT = wr_ready;
	assign LINK_RDATA_OUT = lq.rdata;
	assign IRQ_N_OUT = sq.irq_n;
	assign TIME_OUT = sq.tm;

	chk_busy_start: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		adj_go |=> busy && sq.busy_cnt == BUSY_LAST)
		else $error("busy window did not open on adjust");
	chk_busy_length: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		busy && !adj_go && !sec_go |=> !busy
		|| sq.busy_cnt == $past(sq.busy_cnt) - 11'h001)
		else $error("busy stayed up too long");
	chk_adjust_defer: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		!sq.carry_en && !ctrl_wr && sq.ce_f |-> !adj_go && !sec_go)
		else $error("update ran while carry disabled");
	chk_adjust_low: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		adj_go && sq.tm.sec < SEC_HALF |=> sq.tm.sec == 6'h00
		&& sq.sub == 11'h000 && sq.tm.min == $past(sq.tm.min))
		else $error("low adjust wrong");
	chk_adjust_high: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		adj_go && sq.tm.sec >= SEC_HALF && sq.tm.min < MIN_MAX |=>
		sq.tm.sec == 6'h00 && sq.tm.min == $past(sq.tm.min) + 6'h01)
		else $error("high adjust wrong");
	chk_carry_held: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		sec_carry && !sn.carry_en |=> sq.carry_pend
		&& sq.tm.sec == $past(sq.tm.sec))
		else $error("held carry lost or applied");
	chk_ce_force: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		!sq.ce_f |=> sq.carry_en)
		else $error("carry enable not forced");
	chk_halt_set: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		!sq.ce_f && !sq.osc_f |=> sq.osc_halt [*2])
		else $error("halt flag not set");
	chk_halt_keep: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		sq.ce_f && !ctrl_wr |=> sq.osc_halt == $past(sq.osc_halt))
		else $error("halt flag moved with chip enable high");
	chk_alarm_irq: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		ALARM_ENABLE_IN && ALARM_MATCH_IN |=> sq.alarm_flag && !IRQ_N_OUT)
		else $error("alarm did not pull interrupt");
	chk_pulse_flag: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		!sq.cycle[BIT_LEVEL_MODE] && !sq.alarm_flag |-> sq.periodic_flag == !IRQ_N_OUT)
		else $error("periodic flag disagrees with pin");
	chk_level_hold: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
		sq.cycle[BIT_LEVEL_MODE] && sq.periodic_flag && !ctrl_wr && !cyc_wr
		|=> sq.periodic_flag && !IRQ_N_OUT)
		else $error("level interrupt released by itself");
endmodule : rcf_top
`default_nettype wire

// file: verif/rcf_host.sv
// Host model on the link side: makes the link clock only during an
// access and issues nibble writes and reads one at a time.
// Assumes the rcf_top link handshake with ready high when idle.
`timescale 1ns/1ps
`default_nettype none
module rcf_host (
	output logic                 link_clk_out,
	output logic                 link_wr_out,
	output rcf_pkg::rcf_access_t link_acc_out,
	output logic [3:0]           link_raddr_out,
	input  wire logic            link_ready_in,
	input  wire logic [3:0]      link_rdata_in
);
	import rcf_pkg::*;
	logic run;
	int   hang;
	initial begin
		run = 1'b0;
		hang = 0;
		link_clk_out = 1'b0;
		link_wr_out = 1'b0;
		link_acc_out = 8'h5A;
		link_raddr_out = 4'h0;
		forever begin
			#6;
			// Clock parks low between accesses
			link_clk_out = run ? ~link_clk_out : 1'b0;
		end
	end
	task automatic wait_ready();
		int n;
		n = 0;
		while (link_ready_in !== 1'b1 && n < 300) begin
			@(negedge link_clk_out);
			n++;
		end
		if (n >= 300) begin
			hang++;
		end
	endtask : wait_ready
	task automatic wr(input logic [3:0] a, input logic [3:0] d);
		run = 1'b1;
		@(negedge link_clk_out);
		wait_ready();
		link_acc_out = '{addr: a, data: d};
		link_wr_out = 1'b1;
		@(posedge link_clk_out);
		@(negedge link_clk_out);
		link_wr_out = 1'b0;
		// Released bus shows no stale value
		link_acc_out = ~link_acc_out;
		@(negedge link_clk_out);
		wait_ready();
		run = 1'b0;
	endtask : wr
	// Snapshot lags a few cycles of both clocks, so wait it out
	task automatic rd(input logic [3:0] a, output logic [3:0] d);
		logic [3:0] again;
		int         k;
		run = 1'b1;
		link_raddr_out = a;
		k = 0;
		repeat (80) @(negedge link_clk_out);
		d = link_rdata_in;
		again = ~d;
		// Read until two agree, so a torn snapshot never counts
		while (d !== again && k < 16) begin
			again = d;
			repeat (8) @(negedge link_clk_out);
			d = link_rdata_in;
			k++;
		end
		run = 1'b0;
	endtask : rd
endmodule : rcf_host
`default_nettype wire

// file: verif/rcf_top_tb.sv
// Self-checking bench for rcf_top with the host model on the link.
// Assumes a shortened timebase: HALF_CYC of 4, one second 8192 cycles.
`timescale 1ns/1ps
`default_nettype none
module rcf_top_tb;
	import rcf_pkg::*;
	localparam int HC = 4;
	localparam int SEC_CYC = 2048 * HC;
	logic        sys_clk, rst_n, ce, osc_run, al_en, al_match;
	logic        link_clk, link_wr, wr_ready, irq_n;
	logic [4:0]  mdays;
	logic [3:0]  raddr, rdata, rv;
	rcf_access_t link_acc;
	rcf_time_t   tm;
	logic [5:0]  s0;
	int          error_cnt, samples_checked, seed, n, sp;

	rcf_top #(.HALF_CYC(HC)) rcf_top_inst (
		.SYS_CLK_IN(sys_clk), .RST_N_IN(rst_n), .CE_IN(ce),
		.OSC_RUN_IN(osc_run), .ALARM_ENABLE_IN(al_en),
		.ALARM_MATCH_IN(al_match), .MONTH_DAYS_IN(mdays),
		.LINK_CLK_IN(link_clk), .LINK_WR_IN(link_wr),
		.LINK_ACC_IN(link_acc), .LINK_RADDR_IN(raddr),
		.LINK_WR_READY_OUT(wr_ready), .LINK_RDATA_OUT(rdata),
		.IRQ_N_OUT(irq_n), .TIME_OUT(tm));
	rcf_host rcf_host_inst (
		.link_clk_out(link_clk), .link_wr_out(link_wr),
		.link_acc_out(link_acc), .link_raddr_out(raddr),
		.link_ready_in(wr_ready), .link_rdata_in(rdata));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic results();
		$display("checks=%0d errors=%0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results
	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask : cyc
	// Low cycles seen over a whole number of wave periods
	function automatic logic [31:0] exp_low(input logic [3:0] c, input int s);
		if (c[1:0] == 2'b00) begin
			return 32'h0;
		end
		if (c[1:0] == 2'b01) begin
			return 32'(s);
		end
		return 32'(s / 2);
	endfunction : exp_low

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial begin
		#(8_000_000);
		error_cnt++;
		results();
	end
	initial begin
		seed = 99600;
		error_cnt = 0;
		samples_checked = 0;
		rst_n = 1'b0;
		ce = 1'b1;
		osc_run = 1'b1;
		al_en = 1'b0;
		al_match = 1'b0;
		mdays = 5'(28 + $unsigned($random(seed)) % 4);
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_n = 1'b1;
		cyc(10);
		chk(irq_n, 1);
		chk(tm, 32'h0000_0001);
		for (int a = 0; a < 16; a += 7) begin
			rcf_host_inst.rd(4'(a), rv);
			chk(rv, 0);
		end
		ce = 1'b0;
		osc_run = 1'b0;
		cyc(10);
		osc_run = 1'b1;
		cyc(10);
		ce = 1'b1;
		cyc(10);
		rcf_host_inst.rd(ADDR_CTRL_ONE, rv);
		chk(rv[1], 1);
		rcf_host_inst.wr(ADDR_CTRL_ONE, 4'h6);
		rcf_host_inst.rd(ADDR_CTRL_ONE, rv);
		chk(rv[1], 0);
		osc_run = 1'b0;
		cyc(10);
		osc_run = 1'b1;
		cyc(10);
		rcf_host_inst.rd(ADDR_CTRL_ONE, rv);
		chk(rv[1], 0);
		for (int c = 0; c < 8; c++) begin
			rcf_host_inst.wr(ADDR_IRQ_CYCLE, 4'(c));
			rcf_host_inst.wr(ADDR_CTRL_ONE, 4'hA);
			cyc(10);
			sp = (c % 4 == 3) ? 4096 : 64;
			n = 0;
			repeat (sp) begin
				@(negedge sys_clk);
				if (irq_n === 1'b0) begin
					n++;
				end
			end
			chk(n, exp_low(4'(c), sp));
		end
		rcf_host_inst.wr(ADDR_IRQ_CYCLE, 4'h0);
		n = 0;
		while (tm.sec === 6'h00 && n < 9000) begin
			cyc(1);
			n++;
		end
		rcf_host_inst.wr(ADDR_CTRL_ONE, 4'h4);
		s0 = tm.sec;
		rcf_host_inst.wr(ADDR_CTRL_ONE, 4'h5);
		cyc(20);
		chk(tm.sec, s0);
		rcf_host_inst.wr(ADDR_CTRL_ONE, 4'h2);
		cyc(5);
		chk(tm.sec, 0);
		chk(tm.min, 0);
		rcf_host_inst.rd(ADDR_CTRL_ONE, rv);
		chk(rv[0], 1);
		cyc(1300);
		rcf_host_inst.rd(ADDR_CTRL_ONE, rv);
		chk(rv[0], 0);
		rcf_host_inst.wr(ADDR_CTRL_ONE, 4'h4);
		cyc(7600);
		chk(tm.sec, 0);
		rcf_host_inst.wr(ADDR_CTRL_ONE, 4'h6);
		cyc(5);
		chk(tm.sec, 1);
		rcf_host_inst.wr(ADDR_CTRL_ONE, 4'h4);
		ce = 1'b0;
		cyc(10);
		ce = 1'b1;
		cyc(SEC_CYC);
		chk(tm.sec, 2);
		rcf_host_inst.wr(ADDR_IRQ_CYCLE, 4'h8);
		n = 0;
		while (irq_n !== 1'b0 && n < SEC_CYC + 100) begin
			cyc(1);
			n++;
		end
		rcf_host_inst.rd(ADDR_CTRL_ONE, rv);
		chk(rv[3], 1);
		cyc(50);
		chk(irq_n, 0);
		rcf_host_inst.wr(ADDR_CTRL_ONE, 4'h2);
		cyc(3);
		chk(irq_n, 1);
		rcf_host_inst.wr(ADDR_CTRL_ONE, 4'hA);
		cyc(3);
		chk(irq_n, 0);
		rcf_host_inst.wr(ADDR_IRQ_CYCLE, 4'h0);
		rcf_host_inst.wr(ADDR_CTRL_ONE, 4'h2);
		repeat (20) begin
			@(negedge sys_clk);
			al_match = 1'($random(seed));
		end
		cyc(5);
		chk(irq_n, 1);
		rcf_host_inst.rd(ADDR_CTRL_ONE, rv);
		chk(rv[2], 0);
		al_match = 1'b1;
		al_en = 1'b1;
		cyc(5);
		chk(irq_n, 0);
		rcf_host_inst.rd(ADDR_CTRL_ONE, rv);
		chk(rv[2], 1);
		al_match = 1'b0;
		rcf_host_inst.wr(ADDR_CTRL_ONE, 4'h2);
		cyc(5);
		chk(irq_n, 1);
		chk(rcf_host_inst.hang, 0);
		results();
	end
endmodule : rcf_top_tb
`default_nettype wire
